// File: cht_pkg.sv
// Shared constants for the charger telemetry register bank
package cht_pkg;
    localparam int          NUM_WORDS       = 9;
    localparam int          WORD_W          = 16;
    localparam int          CALC_W          = 32;
    // Byte addresses of the telemetry words
    localparam logic [7:0]  ADDR_TEMP       = 8'h00;
    localparam logic [7:0]  ADDR_POUT       = 8'h02;
    localparam logic [7:0]  ADDR_PIN        = 8'h04;
    localparam logic [7:0]  ADDR_EFF        = 8'h06;
    localparam logic [7:0]  ADDR_IOUT       = 8'h08;
    localparam logic [7:0]  ADDR_IIN        = 8'h0a;
    localparam logic [7:0]  ADDR_VBAT       = 8'h0c;
    localparam logic [7:0]  ADDR_VIN_FB     = 8'h0e;
    localparam logic [7:0]  ADDR_VIN_PANEL  = 8'h10;
    localparam logic [7:0]  ADDR_LAST       = 8'h10;
    // Reset values and sentinels
    localparam logic [15:0] TEMP_UNMEASURED = 16'h7fff;
    localparam logic [15:0] TEMP_ABSENT     = 16'h7777;
    localparam logic [15:0] WORD_INVALID    = 16'hffff;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;
    localparam logic [15:0] WORD_SAT        = 16'hfffe;
    localparam logic [15:0] PANEL_RESET     = 16'hffff;
    localparam logic [15:0] UNMAPPED_READ   = 16'h0000;
    // Scaling: mA * cV / 1000 = cW, cW * 10000 / cW = 0.01 percent
    localparam logic [31:0] POWER_DIV       = 32'h0000_03e8;
    localparam logic [31:0] EFF_SCALE       = 32'h0000_2710;
    localparam logic [31:0] EFF_MAX         = 32'h0000_270f;
endpackage : cht_pkg

// File: cht_divider.sv
// Sequential restoring divider shared by the derived telemetry words
module cht_divider #(
    parameter int WIDTH = 32
)(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] dividend,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  busy,
    output logic                  done,
    output logic      [WIDTH-1:0] quotient
);
    localparam int CW = $clog2(WIDTH + 1);

    logic [WIDTH-1:0] rem_reg;
    logic [WIDTH-1:0] quo_reg;
    logic [WIDTH-1:0] div_reg;
    logic [CW-1:0]    cnt_reg;
    logic             busy_reg;
    logic             done_reg;
    logic [WIDTH:0]   shifted;
    logic             fits;
    logic [WIDTH:0]   diff;

    // Divisor must be nonzero; the caller screens zero before starting
    assign shifted  = {rem_reg, quo_reg[WIDTH-1]};
    assign fits     = shifted >= {1'b0, div_reg};
    assign diff     = shifted - {1'b0, div_reg};
    assign busy     = busy_reg;
    assign done     = done_reg;
    assign quotient = quo_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rem_reg  <= '0;
            quo_reg  <= '0;
            div_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (start && !busy_reg)
        begin
            rem_reg  <= '0;
            quo_reg  <= dividend;
            div_reg  <= divisor;
            cnt_reg  <= CW'(WIDTH);
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            rem_reg  <= fits ? diff[WIDTH-1:0] : shifted[WIDTH-1:0];
            quo_reg  <= {quo_reg[WIDTH-2:0], fits};
            cnt_reg  <= cnt_reg - CW'(1);
            busy_reg <= cnt_reg != CW'(1);
            done_reg <= cnt_reg == CW'(1);
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end
endmodule // cht_divider

// File: cht_read_port.sv
// Word read port: snapshots one whole telemetry word per request
module cht_read_port
    import cht_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          rd_req,
    input  wire logic [7:0]                    rd_addr,
    input  wire logic [NUM_WORDS*WORD_W-1:0]   bank,
    output logic      [WORD_W-1:0]             rd_data,
    output logic                               rd_valid
);
    logic [WORD_W-1:0] data_reg;
    logic              valid_reg;
    logic [6:0]        word_idx;
    logic              addr_hit;
    logic [WORD_W-1:0] sel_word;

    // Both bytes leave from one register so a word never mixes two updates
    assign word_idx = rd_addr[7:1];
    assign addr_hit = !rd_addr[0] && (rd_addr <= ADDR_LAST);
    assign sel_word = addr_hit ? bank[word_idx*WORD_W +: WORD_W] : UNMAPPED_READ;
    assign rd_data  = data_reg;
    assign rd_valid = valid_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            data_reg  <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= rd_req;
            if (rd_req)
                data_reg <= sel_word;
        end
    end

    chk_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
        rd_req |=> rd_valid && (rd_data == $past(sel_word)))
        else $error("read answer missing or wrong");
endmodule // cht_read_port

// File: cht_telemetry_bank.sv
// Charger telemetry register bank with derived power and efficiency words
//////////////////////////////////////////////////////////////////////////////

// Functional notes
// - Nine read-only 16-bit words at even addresses 0x00 through 0x10.
// - Temperature is signed tenths of a degree from thermistor sense.
// - Temperature reads 0x7fff from reset until first conversion finishes.
// - High thermistor voltage means battery absent; temperature becomes 0x7777.
// - Both power words are unsigned hundredths of a watt.
// - Output power is latest output current times latest battery voltage.
// - Input power uses input current times panel-sense voltage when solar.
// - Panel-sense held low selects DC mode; use feedback voltage instead.
// - Input power needs input sense resistor; DC mode also divider and DAC.
// - Efficiency is output over input power, hundredths of percent, max 99.99.
// - Output current is unsigned milliamps from the current-monitor voltage.
// - Output current needs sense and monitor; power adds DAC and dividers.
// - Any needed zero resistor setting makes that derived word 0xffff.
// - Battery voltage in hundredths of a volt, zero until first measured.
// - In solar mode feedback voltage word reads zero; panel word carries input.
module cht_telemetry_bank
    import cht_pkg::*;
#(
    parameter logic [31:0] IOUT_GAIN = 32'h0000_03e8
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        rd_req,
    input  wire logic [7:0]  rd_addr,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    input  wire logic        temp_done,
    input  wire logic [15:0] temp_code,
    input  wire logic        tsense_absent,
    input  wire logic        ior_done,
    input  wire logic [15:0] ior_code,
    input  wire logic        vbat_done,
    input  wire logic [15:0] vbat_code,
    input  wire logic        iin_done,
    input  wire logic [15:0] iin_code,
    input  wire logic        vin_fb_done,
    input  wire logic [15:0] vin_fb_code,
    input  wire logic        vin_panel_done,
    input  wire logic [15:0] vin_panel_code,
    input  wire logic        panel_sense_input,
    input  wire logic [15:0] input_sense_resistor_setting,
    input  wire logic [15:0] output_sense_resistor_setting,
    input  wire logic [15:0] output_monitor_resistor_setting,
    input  wire logic [15:0] output_dac_resistor_setting,
    input  wire logic [15:0] output_divider_upper_setting,
    input  wire logic [15:0] output_divider_lower_setting,
    input  wire logic [15:0] input_dac_resistor_setting,
    input  wire logic [15:0] input_divider_upper_setting,
    input  wire logic [15:0] input_divider_lower_setting
);
    typedef enum logic [2:0] {ST_IDLE, ST_IOUT, ST_POUT, ST_PIN, ST_EFF} cht_step_type;

    cht_step_type state_reg;
    cht_step_type state_next;
    logic [15:0]  battery_temperature_reg;
    logic [15:0]  output_power_reg;
    logic [15:0]  input_power_reg;
    logic [15:0]  conversion_efficiency_reg;
    logic [15:0]  output_current_reg;
    logic [15:0]  input_current_reg;
    logic [15:0]  battery_voltage_reg;
    logic [15:0]  input_voltage_feedback_reg;
    logic [15:0]  input_voltage_panel_sense_reg;
    logic         temp_seen_reg;
    logic         vbat_seen_reg;
    logic         pend_reg;
    logic         launch_reg;
    logic         panel_meta_reg;
    logic         panel_sync_reg;
    logic         dc_mode_reg;
    logic         div_busy;
    logic         div_done;
    logic [31:0]  div_q;
    logic [31:0]  div_num;
    logic [31:0]  div_den;
    logic         step_bad;
    logic         step_zero;
    logic         div_start;
    logic         step_end;
    logic [15:0]  step_word;
    logic [15:0]  pin_volts;
    logic         iout_bad;
    logic         pout_bad;
    logic         pin_bad;
    logic         eff_bad;
    logic         meas_event;
    logic [NUM_WORDS*WORD_W-1:0] bank;

    //////////////////////////////////////////////////////////////////////////
    // Panel-sense pin is asynchronous; two stages before use
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            panel_meta_reg <= 1'b1;
            panel_sync_reg <= 1'b1;
            dc_mode_reg    <= 1'b0;
        end
        else
        begin
            panel_meta_reg <= panel_sense_input;
            panel_sync_reg <= panel_meta_reg;
            dc_mode_reg    <= !panel_sync_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Step selection and screening
    assign iout_bad  = (output_sense_resistor_setting == 16'h0000)
                     || (output_monitor_resistor_setting == 16'h0000);
    assign pout_bad  = iout_bad || (output_dac_resistor_setting == 16'h0000)
                     || (output_divider_upper_setting == 16'h0000)
                     || (output_divider_lower_setting == 16'h0000);
    assign pin_bad   = (input_sense_resistor_setting == 16'h0000)
                     || (dc_mode_reg && ((input_dac_resistor_setting == 16'h0000)
                     || (input_divider_upper_setting == 16'h0000)
                     || (input_divider_lower_setting == 16'h0000)));
    assign eff_bad   = pout_bad || pin_bad;
    assign pin_volts = dc_mode_reg ? input_voltage_feedback_reg : input_voltage_panel_sense_reg;
    assign step_bad  = (state_reg == ST_IOUT) ? iout_bad :
                       (state_reg == ST_POUT) ? pout_bad :
                       (state_reg == ST_PIN)  ? pin_bad  :
                       (state_reg == ST_EFF)  ? eff_bad  : 1'b0;
    // No input power means no ratio; report zero rather than divide by zero
    assign step_zero = (state_reg == ST_EFF) && (input_power_reg == 16'h0000);
    assign div_num   = (state_reg == ST_IOUT) ? 32'(ior_code) * IOUT_GAIN :
                       (state_reg == ST_POUT) ? 32'(output_current_reg) * 32'(battery_voltage_reg) :
                       (state_reg == ST_PIN)  ? 32'(input_current_reg) * 32'(pin_volts) :
                       32'(output_power_reg) * EFF_SCALE;
    assign div_den   = (state_reg == ST_IOUT) ? 32'(output_sense_resistor_setting)
                                                * 32'(output_monitor_resistor_setting) :
                       (state_reg == ST_EFF)  ? 32'(input_power_reg) : POWER_DIV;
    assign div_start = launch_reg && !step_bad && !step_zero;
    assign step_end  = (launch_reg && (step_bad || step_zero)) || div_done;
    assign step_word = (launch_reg && step_bad) ? WORD_INVALID :
                       (launch_reg && step_zero) ? WORD_ZERO :
                       (state_reg == ST_EFF) ? ((div_q > EFF_MAX) ? EFF_MAX[15:0] : div_q[15:0]) :
                       ((div_q > 32'(WORD_SAT)) ? WORD_SAT : div_q[15:0]);
    assign meas_event = ior_done || vbat_done || iin_done || vin_fb_done || vin_panel_done;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (pend_reg) state_next = ST_IOUT;
            ST_IOUT: if (step_end) state_next = ST_POUT;
            ST_POUT: if (step_end) state_next = ST_PIN;
            ST_PIN:  if (step_end) state_next = ST_EFF;
            ST_EFF:  if (step_end) state_next = ST_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer: a new measurement during a pass keeps the pending flag set
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg  <= ST_IDLE;
            pend_reg   <= 1'b0;
            launch_reg <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            pend_reg   <= meas_event || (pend_reg && state_reg != ST_IDLE);
            launch_reg <= (state_next != state_reg) && (state_next != ST_IDLE);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            output_current_reg        <= WORD_ZERO;
            output_power_reg          <= WORD_ZERO;
            input_power_reg           <= WORD_ZERO;
            conversion_efficiency_reg <= WORD_ZERO;
        end
        else if (step_end)
        begin
            unique case (state_reg)
                ST_IOUT: output_current_reg        <= step_word;
                ST_POUT: output_power_reg          <= step_word;
                ST_PIN:  input_power_reg           <= step_word;
                ST_EFF:  conversion_efficiency_reg <= step_word;
                default: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Measured words
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            battery_temperature_reg       <= TEMP_UNMEASURED;
            temp_seen_reg                 <= 1'b0;
            battery_voltage_reg           <= WORD_ZERO;
            vbat_seen_reg                 <= 1'b0;
            input_current_reg             <= WORD_ZERO;
            input_voltage_feedback_reg    <= WORD_ZERO;
            input_voltage_panel_sense_reg <= PANEL_RESET;
        end
        else
        begin
            if (temp_done)
            begin
                battery_temperature_reg <= tsense_absent ? TEMP_ABSENT : temp_code;
                temp_seen_reg           <= 1'b1;
            end
            if (vbat_done)
            begin
                battery_voltage_reg <= vbat_code;
                vbat_seen_reg       <= 1'b1;
            end
            if (iin_done)
                input_current_reg <= iin_code;
            if (!dc_mode_reg)
                input_voltage_feedback_reg <= WORD_ZERO;
            else if (vin_fb_done)
                input_voltage_feedback_reg <= vin_fb_code;
            if (dc_mode_reg)
                input_voltage_panel_sense_reg <= WORD_ZERO;
            else if (vin_panel_done)
                input_voltage_panel_sense_reg <= vin_panel_code;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Word bank in address order and the read port
    assign bank = {input_voltage_panel_sense_reg, input_voltage_feedback_reg, battery_voltage_reg,
                   input_current_reg, output_current_reg, conversion_efficiency_reg,
                   input_power_reg, output_power_reg, battery_temperature_reg};

    cht_divider #(
        .WIDTH    (CALC_W)
    ) u_divider (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .start    (div_start),
        .dividend (div_num),
        .divisor  (div_den),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_q)
    );

    cht_read_port u_read_port (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .rd_req   (rd_req),
        .rd_addr  (rd_addr),
        .bank     (bank),
        .rd_data  (rd_data),
        .rd_valid (rd_valid)
    );

    //////////////////////////////////////////////////////////////////////////
    // Checks
    chk_temp_unmeasured: assert property (@(posedge clk) disable iff (sys_rst)
        !temp_seen_reg |-> battery_temperature_reg == TEMP_UNMEASURED)
        else $error("temperature left unmeasured marker early");
    chk_temp_absent: assert property (@(posedge clk) disable iff (sys_rst)
        temp_done && tsense_absent |=> battery_temperature_reg == TEMP_ABSENT)
        else $error("absent battery not flagged");
    chk_temp_load: assert property (@(posedge clk) disable iff (sys_rst)
        temp_done && !tsense_absent |=> battery_temperature_reg == $past(temp_code))
        else $error("temperature not loaded");
    chk_vbat_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !vbat_seen_reg |-> battery_voltage_reg == WORD_ZERO)
        else $error("battery voltage nonzero before measurement");
    chk_solar_fb_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !dc_mode_reg |=> input_voltage_feedback_reg == WORD_ZERO)
        else $error("feedback voltage not zero in solar mode");
    chk_pout_invalid: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_POUT && launch_reg && pout_bad |=> output_power_reg == WORD_INVALID)
        else $error("output power not invalid with zero setting");
    chk_pin_invalid: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_PIN && launch_reg && input_sense_resistor_setting == 16'h0000
        |=> input_power_reg == WORD_INVALID)
        else $error("input power not invalid with zero sense setting");
    chk_eff_limit: assert property (@(posedge clk) disable iff (sys_rst)
        conversion_efficiency_reg != WORD_INVALID |-> 32'(conversion_efficiency_reg) <= EFF_MAX)
        else $error("efficiency above limit");
    chk_iout_bounded: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_IOUT && launch_reg |-> ##[1:36] state_reg == ST_POUT)
        else $error("output current step overran");
    chk_pass_runs: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_IDLE && pend_reg |=> state_reg == ST_IOUT && launch_reg)
        else $error("pending pass not started");
    // A step launched onto a busy divider would be dropped and its word loaded with the running division's quotient
    chk_div_idle_launch: assert property (@(posedge clk) disable iff (sys_rst)
        launch_reg |-> !div_busy)
        else $error("step launched while divider busy");

    cov_absent: cover property (@(posedge clk) disable iff (sys_rst) temp_done && tsense_absent);
    cov_dc_pin: cover property (@(posedge clk) disable iff (sys_rst) state_reg == ST_PIN && dc_mode_reg && div_done);
    cov_eff_clamp: cover property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_EFF && div_done && div_q > EFF_MAX);
endmodule // cht_telemetry_bank

// File: cht_host_model.sv
// Behavioural host that fetches whole telemetry words from the bank
module cht_host_model
(
    input  wire logic        clk,
    output logic             rd_req,
    output logic [7:0]       rd_addr,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        rd_req  = 1'b0;
        rd_addr = 8'h00;
    end
    // Whole word in one request, never two byte reads
    task automatic read_word(input logic [7:0] a, output logic [15:0] w, output logic v);
        @(negedge clk);
        rd_req  = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_req  = 1'b0;
        // Released address shows junk, so a stale address cannot hide a fault
        rd_addr = ~a;
        v       = rd_valid;
        w       = rd_data;
    endtask
endmodule // cht_host_model

// File: cht_telemetry_bank_tb.sv
// Self-checking bench for the charger telemetry register bank
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module cht_telemetry_bank_tb;
    import cht_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, sys_rst = 1'b1, rd_req, rd_valid, meas_done = 1'b0;
    logic        temp_done = 1'b0, tsense_absent = 1'b0, panel_sense_input = 1'b1;
    logic [7:0]  rd_addr;
    logic [15:0] rd_data, temp_code = 16'h0000, ior_code = 16'h07d0, vbat_code = 16'h04b0;
    logic [15:0] iin_code = 16'h0bb8, vin_fb_code = 16'h0320, vin_panel_code = 16'h03e8;
    logic [15:0] cfg [9];
    int          failures = 0, comparisons = 0, cyc = 0;
    //////////////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;
    // One shared strobe for the five measurements keeps every pass aligned
    cht_telemetry_bank dut (.clk(clk), .sys_rst(sys_rst), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .temp_done(temp_done), .temp_code(temp_code),
        .tsense_absent(tsense_absent), .ior_done(meas_done), .ior_code(ior_code),
        .vbat_done(meas_done), .vbat_code(vbat_code), .iin_done(meas_done), .iin_code(iin_code),
        .vin_fb_done(meas_done), .vin_fb_code(vin_fb_code), .vin_panel_done(meas_done),
        .vin_panel_code(vin_panel_code), .panel_sense_input(panel_sense_input),
        .input_sense_resistor_setting(cfg[0]), .output_sense_resistor_setting(cfg[1]),
        .output_monitor_resistor_setting(cfg[2]), .output_dac_resistor_setting(cfg[3]),
        .output_divider_upper_setting(cfg[4]), .output_divider_lower_setting(cfg[5]),
        .input_dac_resistor_setting(cfg[6]), .input_divider_upper_setting(cfg[7]),
        .input_divider_lower_setting(cfg[8]));
    cht_host_model host (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid));
    //////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            failures++;
            wrap_up();
        end
    end
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string n);
        logic [15:0] w;
        logic        v;
        host.read_word(a, w, v);
        `CHK("rd_valid", 1'b1, v)
        `CHK(n, e, w)
    endtask
    // Gain 1000 over sense 10 times monitor 100 makes output current equal the code
    task automatic set_cfg(input int k);
        foreach (cfg[i]) cfg[i] = (i == 2) ? 16'h0064 : 16'h000a;
        if (k >= 0) cfg[k] = 16'h0000;
    endtask
    // Waits well past the longest derived pass
    task automatic tick();
        repeat (5) @(negedge clk);
        meas_done = 1'b1;
        @(negedge clk);
        meas_done = 1'b0;
        repeat (400) @(negedge clk);
    endtask
    task automatic temp_pulse(input logic [15:0] c, input logic ab);
        @(negedge clk);
        temp_done     = 1'b1;
        temp_code     = c;
        tsense_absent = ab;
        @(negedge clk);
        temp_done = 1'b0;
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(ADDR_TEMP, 16'h7fff, "temp");
        rd_chk(ADDR_VBAT, 16'h0000, "vbat");
        rd_chk(ADDR_VIN_PANEL, 16'hffff, "vin_panel");
        rd_chk(8'h03, 16'h0000, "odd");
        rd_chk(8'h12, 16'h0000, "beyond");
        $display("test reset done");
    endtask
    task automatic t_temp();
        temp_pulse(16'hff38, 1'b0);
        rd_chk(ADDR_TEMP, 16'hff38, "temp");
        temp_pulse(16'h0100, 1'b1);
        rd_chk(ADDR_TEMP, 16'h7777, "temp");
        $display("test temperature done");
    endtask
    task automatic t_solar();
        tick();
        rd_chk(ADDR_IOUT, 16'h07d0, "iout");
        rd_chk(ADDR_POUT, 16'h0960, "pout");
        rd_chk(ADDR_PIN, 16'h0bb8, "pin");
        rd_chk(ADDR_EFF, 16'h1f40, "eff");
        rd_chk(ADDR_VIN_FB, 16'h0000, "vin_fb");
        rd_chk(ADDR_VIN_PANEL, 16'h03e8, "vin_panel");
        rd_chk(ADDR_IIN, 16'h0bb8, "iin");
        rd_chk(ADDR_VBAT, 16'h04b0, "vbat");
        $display("test solar done");
    endtask
    task automatic t_dc();
        panel_sense_input = 1'b0;
        tick();
        rd_chk(ADDR_PIN, 16'h0960, "pin");
        rd_chk(ADDR_EFF, 16'h270f, "eff");
        rd_chk(ADDR_VIN_FB, 16'h0320, "vin_fb");
        rd_chk(ADDR_VIN_PANEL, 16'h0000, "vin_panel");
        $display("test dc done");
    endtask
    task automatic t_zero();
        set_cfg(0);
        tick();
        rd_chk(ADDR_PIN, 16'hffff, "pin");
        rd_chk(ADDR_EFF, 16'hffff, "eff");
        set_cfg(6);
        tick();
        rd_chk(ADDR_PIN, 16'hffff, "pin");
        set_cfg(2);
        tick();
        rd_chk(ADDR_IOUT, 16'hffff, "iout");
        rd_chk(ADDR_POUT, 16'hffff, "pout");
        set_cfg(5);
        tick();
        rd_chk(ADDR_IOUT, 16'h07d0, "iout");
        rd_chk(ADDR_POUT, 16'hffff, "pout");
        panel_sense_input = 1'b1;
        set_cfg(6);
        tick();
        rd_chk(ADDR_PIN, 16'h0bb8, "pin");
        set_cfg(-1);
        tick();
        rd_chk(ADDR_POUT, 16'h0960, "pout");
        // Full-scale current saturates below the sentinel; no input power gives zero ratio
        ior_code = 16'hffff;
        iin_code = 16'h0000;
        tick();
        rd_chk(ADDR_IOUT, 16'hfffe, "iout");
        rd_chk(ADDR_POUT, 16'hfffe, "pout");
        rd_chk(ADDR_PIN, 16'h0000, "pin");
        rd_chk(ADDR_EFF, 16'h0000, "eff");
        $display("test zero settings done");
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        set_cfg(-1);
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_temp();
        t_solar();
        t_dc();
        t_zero();
        wrap_up();
    end
endmodule // cht_telemetry_bank_tb
